// ==== verification/ibc_classifier_chk.sv ====
module ibc_chk
    import ibc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        frm_valid,
    input wire logic [7:0]  frm_id,
    input wire logic [1:0]  frm_tag_cnt,
    input wire logic [15:0] frm_tpid0,
    input wire logic [15:0] frm_tci0,
    input wire logic        frm_ipv4,
    input wire logic        frm_ipv6,
    input wire logic        res_valid,
    input wire logic [7:0]  res_id,
    input wire logic        res_drop,
    input wire logic [2:0]  res_class,
    input wire logic [5:0]  res_dscp,
    input wire logic [11:0] res_vid,
    input wire logic        res_stag,
    input wire logic        res_dei,
    input wire logic [1:0]  res_pop
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] tci0_q;  // outer tag of the previous cycle
    // kept so the header can be tied to the tag it came from
    always_ff @(posedge pclk) begin
        tci0_q <= frm_tci0;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ctag;
        frm_valid && frm_tag_cnt == 2'h1 && frm_tpid0 == TPID_C;
    endsequence
    a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
        else $error("access phase not exactly one cycle");
    a_bad_addr: assert property (psel && !penable && paddr == 12'h020
        |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_rec_follows: assert property (frm_valid |=> res_valid
        && res_id == $past(frm_id)) else $error("record missing or misnamed");
    a_rec_quiet: assert property (!frm_valid |=> !res_valid)
        else $error("record without a frame");
    a_nonip_zero: assert property (frm_valid
        && !frm_ipv4 && !frm_ipv6 |=> res_dscp == 6'h00)
        else $error("non-IP codepoint not zero");
    a_many_tags: assert property (frm_valid
        && frm_tag_cnt == TAGS_MANY |=> res_dscp == 6'h00)
        else $error("codepoint used past two tags");
    a_pop_clip: assert property (frm_valid
        |=> res_pop <= $past(frm_tag_cnt)) else $error("pop count above tags");
    a_ctag_header: assert property (s_ctag
        ##0 frm_tci0[11:0] != 12'h000
        |=> !res_stag && res_vid == tci0_q[11:0] && res_dei == tci0_q[12])
        else $error("header not from customer tag");
    a_stag_flag: assert property (frm_valid && frm_tag_cnt == 2'h1
        && frm_tpid0 == TPID_S |=> res_stag) else $error("service tag missed");
    a_hold_results: assert property (!res_valid
        |-> $stable(res_class) && $stable(res_vid) && $stable(res_drop))
        else $error("record changed between frames");
endmodule : ibc_chk
bind ibc_classifier ibc_chk chk_u (.*);

// ==== verification/ibc_frame_src.sv ====
module ibc_frame_src (
    input  wire logic        pclk,
    output logic             frm_valid,
    output logic [7:0]       frm_id,
    output logic [47:0]      frm_dmac,
    output logic [47:0]      frm_smac,
    output logic             frm_err,
    output logic             frm_mac_ctrl,
    output logic             frm_pause,
    output logic [1:0]       frm_tag_cnt,
    output logic [15:0]      frm_tpid0,
    output logic [15:0]      frm_tci0,
    output logic [15:0]      frm_tpid1,
    output logic [15:0]      frm_tci1,
    output logic             frm_ipv4,
    output logic             frm_ipv6,
    output logic [5:0]       frm_dscp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] seq_r;  // descriptor numbers, one per frame
    // parser idles with no frame pending
    initial begin
        frm_valid = 1'b0;
        seq_r = 8'h00;
        frm_id = 8'h00;
        {frm_dmac, frm_smac, frm_err, frm_mac_ctrl, frm_pause} = '0;
        {frm_tag_cnt, frm_tpid0, frm_tci0, frm_tpid1, frm_tci1} = '0;
        {frm_ipv6, frm_ipv4, frm_dscp} = '0;
    end
    // one-cycle frame pulse, fields only meaningful with the pulse
    task automatic send(input logic [47:0] da, input logic [47:0] sa,
                        input logic [2:0] fl, input logic [1:0] cnt,
                        input logic [31:0] t0, input logic [31:0] t1,
                        input logic [7:0] ip);
        @(posedge pclk);
        frm_valid <= 1'b1;
        frm_id <= seq_r;
        seq_r <= seq_r + 8'h01;
        {frm_dmac, frm_smac} <= {da, sa};
        {frm_err, frm_mac_ctrl, frm_pause} <= fl;
        frm_tag_cnt <= cnt;
        {frm_tpid0, frm_tci0, frm_tpid1, frm_tci1} <= {t0, t1};
        {frm_ipv6, frm_ipv4, frm_dscp} <= ip;
        @(posedge pclk);
        frm_valid <= 1'b0;
        // stale addresses, outer tag and codepoint flip so a late sample never looks right
        {frm_dmac, frm_smac, frm_tpid0, frm_tci0, frm_dscp} <=
            ~{frm_dmac, frm_smac, frm_tpid0, frm_tci0, frm_dscp};
    endtask : send
endmodule : ibc_frame_src

// ==== verification/tb_top.sv ====
module tb_top
    import ibc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] DA = 48'h020000000001;  // unicast peer
    localparam logic [47:0] SA = 48'h020000000002;
    localparam logic [47:0] DAS [4] = '{48'h0180C2000002, 48'h0180C2000021,
                                       48'h0180C2000035, DA};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq, t_k;
    logic        frm_valid, frm_err, frm_mac_ctrl, frm_pause;
    logic        frm_ipv4, frm_ipv6, res_valid, res_drop, res_dp;
    logic        res_dei, res_stag;
    logic [7:0]  frm_id, res_id;
    logic [47:0] frm_dmac, frm_smac, sa_k;
    logic [1:0]  frm_tag_cnt, res_pop;
    logic [15:0] frm_tpid0, frm_tci0, frm_tpid1, frm_tci1;
    logic [5:0]  frm_dscp, res_dscp;
    logic [2:0]  res_class, res_pcp, fl_k;
    logic [11:0] res_vid;
    int          fail_count, n_tests;
    ibc_classifier dut_u (.*);
    ibc_frame_src src_u (.*);
    // free-running bus clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, g, x);
        end
    endtask : cmp
    // one bus transfer, held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rq, re);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rq, re);
        cmp(rq, x);
    endtask : rd
    // frame out, record expected one edge later
    task automatic fr(input logic [47:0] da, input logic [47:0] sa,
                      input logic [2:0] fl, input logic [1:0] cnt,
                      input logic [31:0] t0, input logic [31:0] t1,
                      input logic [7:0] ip);
        src_u.send(da, sa, fl, cnt, t0, t1, ip);
        @(posedge pclk);
        cmp(32'(res_valid), 32'h1);
    endtask : fr
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        fail_count = 0;
        n_tests = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_DROP, 32'h01C);
        rd(OFS_TAG, 32'h1);
        rd(OFS_TPID, 32'h88A8);
        apb(1'b0, 12'h020, 32'h0, rq, re);
        cmp({31'h0, re}, 32'h1);
        cmp(rq, 32'h0);
        $display("test reset done");
        fr(DA, SA, 3'h0, 2'h1, {TPID_C, 16'h6005}, 32'h0, 8'h00);
        cmp({res_drop, res_class, res_dp, res_dscp}, 32'h0);
        cmp({res_pcp, res_dei, res_vid, res_pop}, 32'h18014);
        for (int i = 0; i < 3; i++) begin
            fr(DA, SA, 3'h4 >> i, 2'h1, {TPID_C, 16'h0005}, 32'h0, 8'h00);
            cmp(32'(res_drop), 32'h1);
        end
        // each kind dropped only when its own bit is set
        for (int k = 0; k < 10; k++) begin
            sa_k = (k == 0) ? 48'h010000000002 : (k == 1) ? 48'h0 : SA;
            fl_k = (k == 2) ? 3'h4 : (k == 3) ? 3'h2 : (k == 4) ? 3'h1 : 3'h0;
            t_k = {(k == 6 || k == 8) ? TPID_S : TPID_C, 4'h0,
                   (k == 6 || k == 7) ? 12'h000 : 12'h005};
            for (int d = 1; d >= 0; d--) begin
                wr(OFS_DROP, d ? 32'h1 << k : 32'h0);
                fr(DA, sa_k, fl_k, (k == 5) ? 2'h0 : 2'h1, t_k, 32'h0, 8'h00);
                cmp(32'(res_drop), 32'(d));
            end
        end
        wr(OFS_DROP, 32'h20);
        for (int i = 0; i < 4; i++) begin
            fr(DAS[i], SA, 3'h0, 2'h0, 32'h0, 32'h0, 8'h00);
            cmp(32'(res_drop), 32'(i == 3));
        end
        $display("test acceptance done");
        wr(OFS_DROP, 32'h100);
        for (int i = 0; i < 2; i++) begin
            wr(OFS_TAG, (i == 1) ? 32'h80001 : 32'hA0001);
            fr(DA, SA, 3'h0, 2'h2, {TPID_S, 16'h0123}, {TPID_C, 16'hA456},
               8'h00);
            cmp(32'(res_drop), 32'(i));
            cmp({res_stag, res_vid, res_pcp, res_pop}, (i == 1) ?
                18'h22462 : 18'h08AD6);
        end
        fr(DA, SA, 3'h0, 2'h1, {TPID_C, 16'h0123}, 32'h0, 8'h00);
        cmp(32'(res_pop), 32'h1);
        wr(OFS_TPID, 32'h9100);
        fr(DA, SA, 3'h0, 2'h1, {16'h9100, 16'h0077}, 32'h0, 8'h00);
        cmp({res_stag, res_vid}, 32'h1077);
        $display("test tagging done");
        wr(OFS_DROP, 32'h0);
        // default header with service type and dei set, pcp 5
        wr(OFS_TAG, 32'h1D001);
        wr(OFS_FLOW, 32'h0D);
        fr(DA, SA, 3'h0, 2'h0, 32'h0, 32'h0, 8'h00);
        cmp({res_class, res_dp, res_vid}, 32'hB001);
        cmp({res_stag, res_dei, res_pcp}, 32'h1D);
        wr(OFS_FLOW, 32'h1D);
        wr(12'h074, 32'hE);
        wr(OFS_TAG, 32'h100001);
        rd(12'h074, 32'hE);
        fr(DA, SA, 3'h0, 2'h1, {TPID_C, 16'hB005}, 32'h0, 8'h00);
        cmp({res_class, res_dp, res_pcp, res_dei}, 32'hDD);
        wr(OFS_TAG, 32'h1);
        wr(OFS_FLOW, 32'hE0);
        wr(12'h1A8, 32'h475);
        for (int i = 0; i < 4; i++) begin
            if (i >= 2)
                wr(OFS_FLOW, (i == 2) ? 32'h60 : 32'hE0);
            fr(DA, SA, 3'h0, (i == 3) ? 2'h3 : 2'h2, {TPID_C, 16'h0005},
               {TPID_C, 16'h0006}, (i == 1) ? 8'hAA : 8'h6A);
            cmp({res_class, res_dp, res_dscp},
                (i < 2) ? 32'h151 : 32'h0);
        end
        wr(OFS_FLOW, 32'h80);
        fr(DA, SA, 3'h0, 2'h0, 32'h0, 32'h0, 8'h45);
        cmp(32'(res_dscp), 32'h05);
        // 39 frames so far: 16 discarded, 23 accepted
        rd(OFS_STAT, 32'h00100017);
        $display("test classification done");
        report_and_stop;
    end
    // cuts a hang short long after the sequence should end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("watchdog expired");
        report_and_stop;
    end
endmodule : tb_top

// ==== verilog/ibc_classifier.sv ====
// Contract
// - drop or forward listed frame kinds
// - untagged drop spares reserved addresses
// - reset drops control, pause, errored
// - discard frames with disallowed tagging
// - outer tag, inner if enabled
// - three-bit class attached, seven highest
// - one-bit drop precedence attached
// - six-bit codepoint attached for rewriter
// - codepoint from frame, zero non-IP
// - port default class and precedence
// - priority and DEI feed classification
// - codepoint read behind two tags
// - per-port DEI/PCP map table
// - one shared codepoint translation stage
// - tag header with type flag
// - recognise C, S and custom TPID
// - VLAN and priority tags processed
// - header from frame or default
// - inner tag used when enabled
// - pop count clipped to tags present
// - optional class copied into PCP
// - results exposed for later override
// - more than two tags is non-IP
// - upper layers only when parse enabled
//
// Added by the designer: the APB interface to the registers and the register offsets.
module ibc_classifier
    import ibc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        frm_valid,
    input  wire logic [7:0]  frm_id,
    input  wire logic [47:0] frm_dmac,
    input  wire logic [47:0] frm_smac,
    input  wire logic        frm_err,
    input  wire logic        frm_mac_ctrl,
    input  wire logic        frm_pause,
    input  wire logic [1:0]  frm_tag_cnt,
    input  wire logic [15:0] frm_tpid0,
    input  wire logic [15:0] frm_tci0,
    input  wire logic [15:0] frm_tpid1,
    input  wire logic [15:0] frm_tci1,
    input  wire logic        frm_ipv4,
    input  wire logic        frm_ipv6,
    input  wire logic [5:0]  frm_dscp,
    output logic             res_valid,
    output logic [7:0]       res_id,
    output logic             res_drop,
    output logic [2:0]       res_class,
    output logic             res_dp,
    output logic [5:0]       res_dscp,
    output logic [2:0]       res_pcp,
    output logic             res_dei,
    output logic [11:0]      res_vid,
    output logic             res_stag,
    output logic [1:0]       res_pop
);

    // all state of the block
    typedef struct packed {
        logic               pready;     // apb access ack
        logic [31:0]        prdata;     // apb read word
        logic               pslverr;    // apb unmapped flag
        logic [9:0]         drop_cfg;   // frame kind drop mask
        logic [7:0]         flow_cfg;   // classification flow
        logic [20:0]        tag_cfg;    // port tag config
        logic [15:0]        tpid;       // custom service tpid
        logic [15:0][3:0]   map_tab;    // {dei,pcp} -> {dp,class}
        logic [63:0][11:0]  xl_tab;     // codepoint translation
        logic [15:0]        acc_cnt;    // accepted frames
        logic [15:0]        drp_cnt;    // dropped frames
        ibc_phase_type      phase;      // record output phase
        logic               valid;
        logic [7:0]         id;
        logic               drop;
        logic [2:0]         cls;
        logic               dp;
        logic [5:0]         dscp;
        logic [2:0]         pcp;
        logic               dei;
        logic [11:0]        vid;
        logic               stag;
        logic [1:0]         pop;
    } ibc_state_type;

    ibc_state_type st_r;                // registered state
    ibc_state_type st_nxt;              // next state

    // service tag test against both identifiers
    function automatic logic is_stag(input logic [15:0] t,
                                     input logic [15:0] cust);
        is_stag = (t == TPID_S) || (t == cust);
    endfunction : is_stag

    // any recognised tag identifier
    function automatic logic is_tag(input logic [15:0] t,
                                    input logic [15:0] cust);
        is_tag = (t == TPID_C) || is_stag(t, cust);
    endfunction : is_tag

    // combinational frame decision
    logic        f_tagged;          // selected tag recognised
    logic        f_inner;           // inner tag chosen
    logic [15:0] f_tpid;            // selected identifier
    logic [15:0] f_tci;             // selected control word
    logic        f_s;               // selected is service tag
    logic        f_prio;            // selected vid is zero
    logic        f_rsv;             // reserved destination
    logic        f_ip;              // upper layers usable
    logic [5:0]  f_dscp;            // classified codepoint
    logic [2:0]  f_cls;             // classified class
    logic        f_dp;              // classified precedence
    logic        f_drop;            // acceptance verdict
    logic [11:0] f_xl;              // translation entry
    logic [3:0]  f_map;             // map entry
    logic [1:0]  f_ntag;            // tags actually present
    logic [1:0]  f_popc;            // configured pop count

    // classification of one frame
    always_comb begin
        // outer by default, inner on two or more tags when enabled
        f_inner = st_r.tag_cfg[TGB_INNER] &&
                  (frm_tag_cnt >= 2'h2);
        f_tpid  = f_inner ? frm_tpid1 : frm_tpid0;
        f_tci   = f_inner ? frm_tci1 : frm_tci0;
        f_tagged = (frm_tag_cnt != 2'h0) &&
                   is_tag(f_tpid, st_r.tpid);
        f_s     = is_stag(f_tpid, st_r.tpid);
        f_prio  = (f_tci[11:0] == 12'h000);
        // bpdu 00-0F, garp 20-2F, ccm/link trace 30-3F
        f_rsv   = (frm_dmac[47:8] == RSV_PFX) &&
                  ((frm_dmac[7:4] == 4'h0) ||
                   (frm_dmac[7:4] == 4'h2) ||
                   (frm_dmac[7:4] == 4'h3));
        f_drop  = 1'b0;
        // frame kind filter, defaults drop ctrl/pause/err
        if (st_r.drop_cfg[DRB_MC_SA] && frm_smac[40]) begin
            f_drop = 1'b1;
        end
        if (st_r.drop_cfg[DRB_NULL] &&
            ((frm_smac == NULL_MAC) ||
             (frm_dmac == NULL_MAC))) begin
            f_drop = 1'b1;
        end
        if (st_r.drop_cfg[DRB_ERR] && frm_err) begin
            f_drop = 1'b1;
        end
        if (st_r.drop_cfg[DRB_CTRL] && frm_mac_ctrl) begin
            f_drop = 1'b1;
        end
        if (st_r.drop_cfg[DRB_PAUSE] && frm_pause) begin
            f_drop = 1'b1;
        end
        // vlan acceptance on the selected tag
        if (!f_tagged) begin
            if (st_r.drop_cfg[DRB_UNTAG] && !f_rsv) begin
                f_drop = 1'b1;
            end
        end else if (f_s) begin
            if (st_r.drop_cfg[f_prio ? DRB_PRIO_S : DRB_VLAN_S])
            begin
                f_drop = 1'b1;
            end
        end else begin
            if (st_r.drop_cfg[f_prio ? DRB_PRIO_C : DRB_VLAN_C])
            begin
                f_drop = 1'b1;
            end
        end
        // upper layers: parse on, ip, at most two tags
        f_ip = st_r.flow_cfg[FLB_PARSE] &&
               (frm_ipv4 || frm_ipv6) &&
               (frm_tag_cnt != TAGS_MANY);
        f_dscp = f_ip ? frm_dscp : 6'h00;
        // port defaults first
        f_cls = st_r.flow_cfg[2:0];
        f_dp  = st_r.flow_cfg[FLB_DP];
        // tag priority map keyed by {dei,pcp}
        f_map = st_r.map_tab[{f_tci[12], f_tci[15:13]}];
        if (st_r.flow_cfg[FLB_PCP] && f_tagged) begin
            f_cls = f_map[2:0];
            f_dp  = f_map[3];
        end
        // one translation entry shared by the trust and rewrite paths
        f_xl = st_r.xl_tab[f_dscp];
        if (f_ip && st_r.flow_cfg[FLB_DSCP] &&
            f_xl[XLB_TRUST]) begin
            f_cls = f_xl[XLB_CLASS +: 3];
            f_dp  = f_xl[XLB_DP];
        end
        if (f_ip && st_r.flow_cfg[FLB_XLATE] &&
            f_xl[XLB_XEN]) begin
            f_dscp = f_xl[XLB_DSCP +: 6];
        end
        // tags really present, a count of three caps at three
        f_ntag = f_tagged ? frm_tag_cnt : 2'h0;
        f_popc = st_r.tag_cfg[TGB_POP +: 2];
    end

    // next state: apb slave, config and result record
    always_comb begin
        st_nxt = st_r;
        // ack one cycle after setup, so no wait states
        st_nxt.pready  = psel && !penable;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata  = 32'h00000000;
        // read data latched in setup, stable through access
        if (psel && !penable) begin
            if (paddr == OFS_DROP) begin
                st_nxt.prdata = {22'h000000, st_r.drop_cfg};
            end else if (paddr == OFS_FLOW) begin
                st_nxt.prdata = {24'h000000, st_r.flow_cfg};
            end else if (paddr == OFS_TAG) begin
                st_nxt.prdata = {11'h000, st_r.tag_cfg};
            end else if (paddr == OFS_TPID) begin
                st_nxt.prdata = {16'h0000, st_r.tpid};
            end else if (paddr == OFS_STAT) begin
                st_nxt.prdata = {st_r.drp_cnt, st_r.acc_cnt};
            end else if (paddr >= OFS_MAP && paddr <= OFS_MAP_E
                         && paddr[1:0] == 2'h0) begin
                st_nxt.prdata = {28'h0000000,
                                 st_r.map_tab[paddr[5:2]]};
            end else if (paddr >= OFS_XL && paddr <= OFS_XL_E
                         && paddr[1:0] == 2'h0) begin
                st_nxt.prdata = {20'h00000,
                                 st_r.xl_tab[paddr[7:2]]};
            end else begin
                // unmapped: zero data and an error answer
                st_nxt.pslverr = 1'b1;
            end
        end else begin
            // keep answer stable during access phase
            st_nxt.prdata  = st_r.prdata;
            st_nxt.pslverr = st_r.pslverr && psel;
        end
        // writes take effect at the acknowledged access edge
        if (psel && penable && st_r.pready && pwrite &&
            !st_r.pslverr) begin
            if (paddr == OFS_DROP) begin
                st_nxt.drop_cfg = pwdata[9:0];
            end else if (paddr == OFS_FLOW) begin
                st_nxt.flow_cfg = pwdata[7:0];
            end else if (paddr == OFS_TAG) begin
                st_nxt.tag_cfg = pwdata[20:0];
            end else if (paddr == OFS_TPID) begin
                st_nxt.tpid = pwdata[15:0];
            end else if (paddr >= OFS_MAP &&
                         paddr <= OFS_MAP_E) begin
                st_nxt.map_tab[paddr[5:2]] = pwdata[3:0];
            end else if (paddr >= OFS_XL && paddr <= OFS_XL_E)
            begin
                st_nxt.xl_tab[paddr[7:2]] = pwdata[11:0];
            end else begin
                // status is read only
                st_nxt.tpid = st_r.tpid;
            end
        end
        // result record, one per frame, one cycle later
        st_nxt.valid = frm_valid;
        case (st_r.phase)
            IBC_IDLE: begin
                st_nxt.phase = frm_valid ? IBC_OUT : IBC_IDLE;
            end
            IBC_OUT: begin
                st_nxt.phase = frm_valid ? IBC_OUT : IBC_IDLE;
            end
            default: begin
                st_nxt.phase = IBC_IDLE;
            end
        endcase
        if (frm_valid) begin
            st_nxt.id   = frm_id;
            st_nxt.drop = f_drop;
            st_nxt.cls  = f_cls;
            st_nxt.dp   = f_dp;
            st_nxt.dscp = f_dscp;
            // header from selected tag, else port default
            if (f_tagged) begin
                st_nxt.pcp  = f_tci[15:13];
                st_nxt.dei  = f_tci[12];
                st_nxt.vid  = f_tci[11:0];
                st_nxt.stag = f_s;
            end else begin
                st_nxt.pcp  = st_r.tag_cfg[TGB_PCP +: 3];
                st_nxt.dei  = st_r.tag_cfg[TGB_DEI];
                st_nxt.vid  = st_r.tag_cfg[11:0];
                st_nxt.stag = st_r.tag_cfg[TGB_STYPE];
            end
            if (st_r.tag_cfg[TGB_COPY]) begin
                st_nxt.pcp = f_cls;
            end
            // never pop more tags than the frame carries
            st_nxt.pop = (f_popc > f_ntag) ? f_ntag : f_popc;
            // wrapping frame counters
            if (f_drop) begin
                st_nxt.drp_cnt = st_r.drp_cnt + 16'h0001;
            end else begin
                st_nxt.acc_cnt = st_r.acc_cnt + 16'h0001;
            end
        end
    end

    // state register; constants only under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r          <= '0;
            st_r.drop_cfg <= RST_DROP;
            st_r.flow_cfg <= RST_FLOW;
            st_r.tag_cfg  <= RST_TAG;
            st_r.tpid     <= RST_TPID;
            st_r.phase    <= IBC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign pready    = st_r.pready;
    assign prdata    = st_r.prdata;
    assign pslverr   = st_r.pslverr;
    assign res_valid = st_r.valid;
    assign res_id    = st_r.id;
    assign res_drop  = st_r.drop;
    assign res_class = st_r.cls;
    assign res_dp    = st_r.dp;
    assign res_dscp  = st_r.dscp;
    assign res_pcp   = st_r.pcp;
    assign res_dei   = st_r.dei;
    assign res_vid   = st_r.vid;
    assign res_stag  = st_r.stag;
    assign res_pop   = st_r.pop;

endmodule : ibc_classifier

// ==== verilog/ibc_pkg.sv ====
package ibc_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_DROP   = 12'h000;
    localparam logic [11:0] OFS_FLOW   = 12'h004;
    localparam logic [11:0] OFS_TAG    = 12'h008;
    localparam logic [11:0] OFS_TPID   = 12'h00C;
    localparam logic [11:0] OFS_STAT   = 12'h010;
    localparam logic [11:0] OFS_MAP    = 12'h040;
    localparam logic [11:0] OFS_MAP_E  = 12'h07C;
    localparam logic [11:0] OFS_XL     = 12'h100;
    localparam logic [11:0] OFS_XL_E   = 12'h1FC;
    // drop config bit positions
    localparam int DRB_MC_SA   = 0;
    localparam int DRB_NULL    = 1;
    localparam int DRB_ERR     = 2;
    localparam int DRB_CTRL    = 3;
    localparam int DRB_PAUSE   = 4;
    localparam int DRB_UNTAG   = 5;
    localparam int DRB_PRIO_S  = 6;
    localparam int DRB_PRIO_C  = 7;
    localparam int DRB_VLAN_S  = 8;
    localparam int DRB_VLAN_C  = 9;
    // flow config bit positions
    localparam int FLB_DP      = 3;
    localparam int FLB_PCP     = 4;
    localparam int FLB_DSCP    = 5;
    localparam int FLB_XLATE   = 6;
    localparam int FLB_PARSE   = 7;
    // port tag config bit positions
    localparam int TGB_PCP     = 12;
    localparam int TGB_DEI     = 15;
    localparam int TGB_STYPE   = 16;
    localparam int TGB_INNER   = 17;
    localparam int TGB_POP     = 18;
    localparam int TGB_COPY    = 20;
    // translation entry bit positions
    localparam int XLB_TRUST   = 0;
    localparam int XLB_CLASS   = 1;
    localparam int XLB_DP      = 4;
    localparam int XLB_XEN     = 5;
    localparam int XLB_DSCP    = 6;
    // reset values
    localparam logic [9:0]  RST_DROP   = 10'h01C;
    localparam logic [7:0]  RST_FLOW   = 8'h00;
    localparam logic [20:0] RST_TAG    = 21'h000001;
    localparam logic [15:0] RST_TPID   = 16'h88A8;
    // tag protocol identifiers
    localparam logic [15:0] TPID_C     = 16'h8100;
    localparam logic [15:0] TPID_S     = 16'h88A8;
    // reserved destination prefix and null address
    localparam logic [39:0] RSV_PFX    = 40'h0180C20000;
    localparam logic [47:0] NULL_MAC   = 48'h000000000000;
    localparam logic [1:0]  TAGS_MANY  = 2'h3;
    // frame record path state
    typedef enum logic [0:0] {
        IBC_IDLE,
        IBC_OUT
    } ibc_phase_type;
endpackage : ibc_pkg
